// ### dcrb_params.svh
// Register addresses, field positions and reset values of the converter control bank.
// Assumes inclusion by bare name from each design file that needs the register map.
`ifndef DCRB_PARAMS_SVH
`define DCRB_PARAMS_SVH
`define DCRB_ADDR_W      7
`define DCRB_DATA_W      9
`define DCRB_FRAME_W     16
`define DCRB_ADDR_IFACE  7'h03
`define DCRB_ADDR_L1     7'h04
`define DCRB_ADDR_R1     7'h05
`define DCRB_ADDR_L2     7'h06
`define DCRB_ADDR_R2     7'h07
`define DCRB_ADDR_MASTER 7'h08
`define DCRB_ADDR_EXT    7'h09
`define DCRB_IFACE_RESET 9'h000
`define DCRB_EXT_RESET   2'h0
`define DCRB_LEVEL_RESET 8'hff
`define DCRB_UPDATE_BIT  8
`define DCRB_FMT_LSB     0
`define DCRB_LRP_BIT     2
`define DCRB_BCP_BIT     3
`define DCRB_IWL_LSB     4
`define DCRB_REV_LSB     6
`define DCRB_SPLIT_BIT   0
`define DCRB_ZCD_BIT     1
`endif

// ### dcrb_pkg.sv
// Types shared by the converter control bank modules.
// Assumes dcrb_params.svh is on the include path.
package dcrb_pkg;
  typedef enum logic [1:0]
  {
    DCRB_FMT_RIGHT_JUST = 2'h0,
    DCRB_FMT_LEFT_JUST  = 2'h1,
    DCRB_FMT_I2S        = 2'h2,
    DCRB_FMT_DSP        = 2'h3
  } dcrb_format_t;
  typedef enum logic [1:0]
  {
    DCRB_WL_16 = 2'h0,
    DCRB_WL_20 = 2'h1,
    DCRB_WL_24 = 2'h2,
    DCRB_WL_32 = 2'h3
  } dcrb_word_len_t;
endpackage : dcrb_pkg

// ### dcrb_wr_if.sv
// Register write channel from the serial control receiver to the register bank.
// Assumes both ends run on core_clk; valid is a one-cycle pulse.
`timescale 1ns/1ps
`include "dcrb_params.svh"
interface dcrb_wr_if;
  logic                        valid;
  logic [`DCRB_ADDR_W-1:0]     addr;
  logic [`DCRB_DATA_W-1:0]     data;
  modport src (output valid, output addr, output data);
  modport dst (input valid, input addr, input data);
endinterface : dcrb_wr_if

// ### dcrb_serial_port.sv
// Three-wire control receiver: 16-bit words, address first, taken on the latch rising edge.
// Assumes the pins are asynchronous to core_clk and each pin level lasts at least three core_clk cycles.
`timescale 1ns/1ps
`include "dcrb_params.svh"
module dcrb_serial_port
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic ctl_latch_pin,
  input  wire logic ctl_clock_pin,
  input  wire logic ctl_data_pin,
  dcrb_wr_if.src    wr
);
  import dcrb_pkg::*;

  logic [2:0]                  sync1_r, sync2_r, prev_r;
  logic [`DCRB_FRAME_W-1:0]    shift_r, shift_nxt;
  logic                        valid_r, valid_nxt;
  logic [`DCRB_ADDR_W-1:0]     addr_r, addr_nxt;
  logic [`DCRB_DATA_W-1:0]     data_r, data_nxt;

  // Bit 2 is the latch, bit 1 the shift clock, bit 0 the data; only sync2_r and prev_r are read by logic.
  always_comb
  begin
    shift_nxt = shift_r;
    valid_nxt = 1'b0;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    if (sync2_r[1] && !prev_r[1])
    begin
      shift_nxt = {shift_r[`DCRB_FRAME_W-2:0], sync2_r[0]};
    end
    if (sync2_r[2] && !prev_r[2])
    begin
      valid_nxt = 1'b1;
      addr_nxt  = shift_r[`DCRB_FRAME_W-1:`DCRB_DATA_W];
      data_nxt  = shift_r[`DCRB_DATA_W-1:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
      shift_r <= 16'h0000;
      valid_r <= 1'b0;
      addr_r  <= 7'h00;
      data_r  <= 9'h000;
    end
    else
    begin
      sync1_r <= {ctl_latch_pin, ctl_clock_pin, ctl_data_pin};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      shift_r <= shift_nxt;
      valid_r <= valid_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
    end
  end

  assign wr.valid = valid_r;
  assign wr.addr  = addr_r;
  assign wr.data  = data_r;
endmodule : dcrb_serial_port

// ### dcrb_atten_channel.sv
// One channel of attenuation: intermediate latch, committed target and applied level.
// Assumes load and commit are one-cycle pulses; crossing marks a midrail crossing of this channel.
`timescale 1ns/1ps
module dcrb_atten_channel #(
  parameter int LEVEL_W = 8
)
(
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               load,
  input  wire logic [LEVEL_W-1:0] load_value,
  input  wire logic               commit,
  input  wire logic               crossing,
  input  wire logic               gate_bypass,
  output logic      [LEVEL_W-1:0] applied_level,
  output logic      [LEVEL_W-1:0] pending_level,
  output logic                    update_waiting
);
  logic [LEVEL_W-1:0] latch_r, latch_nxt, target_r, target_nxt, applied_r, applied_nxt;
  logic               wait_r, wait_nxt;

  always_comb
  begin
    latch_nxt   = load ? load_value : latch_r;
    target_nxt  = target_r;
    wait_nxt    = wait_r;
    applied_nxt = applied_r;
    if (commit)
    begin
      target_nxt = latch_nxt;
      wait_nxt   = 1'b1;
    end
    if (wait_nxt && (gate_bypass || crossing))
    begin
      applied_nxt = target_nxt;
      wait_nxt    = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      latch_r   <= {LEVEL_W{1'b1}};
      target_r  <= {LEVEL_W{1'b1}};
      applied_r <= {LEVEL_W{1'b1}};
      wait_r    <= 1'b0;
    end
    else
    begin
      latch_r   <= latch_nxt;
      target_r  <= target_nxt;
      applied_r <= applied_nxt;
      wait_r    <= wait_nxt;
    end
  end

  assign applied_level  = applied_r;
  assign pending_level  = latch_r;
  assign update_waiting = wait_r;
endmodule : dcrb_atten_channel

// ### dcrb_top.sv
// Control register bank of a six-channel audio converter, written over a three-wire serial port.
// Assumes the data path on core_clk consumes the settings and reports midrail crossings as pulses.
`timescale 1ns/1ps
`include "dcrb_params.svh"

// Functional notes
// - Format code 00 right justified, 01 left justified, 10 I2S, 11 DSP.
// - Bit 2 inverts frame clock in justified/I2S, selects late phase in DSP.
// - Bit 3 selects normal or inverted bit clock edge for data and frame.
// - Bits 5:4 pick 16/20/24/32-bit words; host avoids 32-bit right justified.
// - Bits 6, 7, 8 invert output phase of pairs 0, 1, 2; reset zero.
// - Channel attenuation is eight bits in half-decibel steps, resetting to all ones.
// - Pair-1 and pair-2 left/right levels sit at addresses 4, 5, 6, 7.
// - Write with bit 8 clear loads only that channel's intermediate latch.
// - Write with bit 8 set loads value and applies every intermediate latch.
// - The update bit is a strobe and is never stored.
// - Master level at address 8 covers all channels and resets to all ones.
// - Master write copies into every latch; applies only when update bit set.
// - Extended bit 0 at address 9 enables split rate, front 192k, rear 96k.
// - Extended bit 1 clear gates volume changes to midrail crossings; set bypasses.
// - Interface control sits at address 3, format in bits 1:0, resets zero.
module dcrb_top #(
  parameter int LEVEL_W  = 8,
  parameter int CHANNELS = 4
)
(
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  input  wire logic                      ctl_latch_pin,
  input  wire logic                      ctl_clock_pin,
  input  wire logic                      ctl_data_pin,
  input  wire logic [CHANNELS-1:0]       midrail_cross,
  output dcrb_pkg::dcrb_format_t         format_select,
  output logic                           frame_clock_polarity_phase,
  output logic                           frame_clock_invert,
  output logic                           dsp_late_phase,
  output logic                           bit_clock_polarity,
  output dcrb_pkg::dcrb_word_len_t       input_word_length,
  output logic      [5:0]                word_bits,
  output logic                           config_conflict,
  output logic      [2:0]                phase_invert,
  output logic                           split_rate_enable,
  output logic                           rear_half_rate,
  output logic                           zero_cross_disable,
  output logic      [LEVEL_W-1:0]        master_level,
  output logic      [LEVEL_W-1:0]        left_pair1_level,
  output logic      [LEVEL_W-1:0]        right_pair1_level,
  output logic      [LEVEL_W-1:0]        left_pair2_level,
  output logic      [LEVEL_W-1:0]        right_pair2_level,
  output logic      [LEVEL_W-1:0]        left_pair1_pending,
  output logic      [LEVEL_W-1:0]        right_pair1_pending,
  output logic      [LEVEL_W-1:0]        left_pair2_pending,
  output logic      [LEVEL_W-1:0]        right_pair2_pending,
  output logic      [CHANNELS-1:0]       update_waiting,
  output logic                           update_strobe
);
  import dcrb_pkg::*;

  // The register map and channel decode only serve eight-bit levels on four channels.
  if (LEVEL_W != 8)
  begin : g_check_level
    $error("dcrb_top: LEVEL_W must be 8");
  end
  if (CHANNELS != 4)
  begin : g_check_channels
    $error("dcrb_top: CHANNELS must be 4");
  end

  dcrb_wr_if wr ();

  dcrb_serial_port u_serial_port
  (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .ctl_latch_pin (ctl_latch_pin),
    .ctl_clock_pin (ctl_clock_pin),
    .ctl_data_pin  (ctl_data_pin),
    .wr            (wr.src)
  );

  // Register state and the registered copies of derived settings.
  logic [`DCRB_DATA_W-1:0] iface_r, iface_nxt;
  logic [1:0]              ext_r, ext_nxt;
  logic [LEVEL_W-1:0]      master_r, master_nxt;
  logic                    strobe_r, strobe_nxt;
  logic                    frame_inv_r, frame_inv_nxt;
  logic                    dsp_late_r, dsp_late_nxt;
  logic [5:0]              bits_r, bits_nxt;
  logic                    conflict_r, conflict_nxt;

  // Write decode.
  logic                    hit_iface;
  logic                    hit_ext;
  logic                    hit_master;
  logic [CHANNELS-1:0]     hit_chan;
  logic                    hit_any_level;
  logic                    commit_all;
  logic [CHANNELS-1:0]     chan_load;
  logic [LEVEL_W-1:0]      wr_level;
  logic [LEVEL_W-1:0]      applied [CHANNELS];
  logic [LEVEL_W-1:0]      pending [CHANNELS];
  dcrb_format_t            fmt_nxt;
  dcrb_word_len_t          wl_nxt;

  always_comb
  begin
    hit_iface     = wr.valid && (wr.addr == `DCRB_ADDR_IFACE);
    hit_ext       = wr.valid && (wr.addr == `DCRB_ADDR_EXT);
    hit_master    = wr.valid && (wr.addr == `DCRB_ADDR_MASTER);
    hit_chan[0]   = wr.valid && (wr.addr == `DCRB_ADDR_L1);
    hit_chan[1]   = wr.valid && (wr.addr == `DCRB_ADDR_R1);
    hit_chan[2]   = wr.valid && (wr.addr == `DCRB_ADDR_L2);
    hit_chan[3]   = wr.valid && (wr.addr == `DCRB_ADDR_R2);
    hit_any_level = hit_master || (|hit_chan);
    wr_level      = wr.data[LEVEL_W-1:0];
    // The update bit only qualifies this write and never reaches a level register.
    commit_all    = hit_any_level && wr.data[`DCRB_UPDATE_BIT];
    // A master write fills every intermediate latch, a channel write only its own.
    chan_load     = hit_chan | {CHANNELS{hit_master}};
  end

  // Next values of the control registers and of the settings derived from them.
  always_comb
  begin
    iface_nxt  = iface_r;
    ext_nxt    = ext_r;
    master_nxt = master_r;
    if (hit_iface)
    begin
      iface_nxt = wr.data;
    end
    if (hit_ext)
    begin
      ext_nxt = wr.data[1:0];
    end
    if (hit_master)
    begin
      master_nxt = wr_level;
    end
    strobe_nxt = commit_all;
    fmt_nxt    = dcrb_format_t'(iface_nxt[`DCRB_FMT_LSB +: 2]);
    wl_nxt     = dcrb_word_len_t'(iface_nxt[`DCRB_IWL_LSB +: 2]);
    // One bit carries polarity in framed formats and phase in DSP framing.
    frame_inv_nxt = iface_nxt[`DCRB_LRP_BIT] && (fmt_nxt != DCRB_FMT_DSP);
    dsp_late_nxt  = iface_nxt[`DCRB_LRP_BIT] && (fmt_nxt == DCRB_FMT_DSP);
    unique case (wl_nxt)
      DCRB_WL_16: bits_nxt = 6'h10;
      DCRB_WL_20: bits_nxt = 6'h14;
      DCRB_WL_24: bits_nxt = 6'h18;
      DCRB_WL_32: bits_nxt = 6'h20;
    endcase
    // The device cannot place 32-bit words right justified; flag it for the data path.
    conflict_nxt = (wl_nxt == DCRB_WL_32) && (fmt_nxt == DCRB_FMT_RIGHT_JUST);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      iface_r     <= `DCRB_IFACE_RESET;
      ext_r       <= `DCRB_EXT_RESET;
      master_r    <= `DCRB_LEVEL_RESET;
      strobe_r    <= 1'b0;
      frame_inv_r <= 1'b0;
      dsp_late_r  <= 1'b0;
      bits_r      <= 6'h10;
      conflict_r  <= 1'b0;
    end
    else
    begin
      iface_r     <= iface_nxt;
      ext_r       <= ext_nxt;
      master_r    <= master_nxt;
      strobe_r    <= strobe_nxt;
      frame_inv_r <= frame_inv_nxt;
      dsp_late_r  <= dsp_late_nxt;
      bits_r      <= bits_nxt;
      conflict_r  <= conflict_nxt;
    end
  end

  // Four identical channels; a commit moves every latch at once.
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_chan
    dcrb_atten_channel #(
      .LEVEL_W (LEVEL_W)
    ) u_chan
    (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .load           (chan_load[ch]),
      .load_value     (wr_level),
      .commit         (commit_all),
      .crossing       (midrail_cross[ch]),
      .gate_bypass    (ext_r[`DCRB_ZCD_BIT]),
      .applied_level  (applied[ch]),
      .pending_level  (pending[ch]),
      .update_waiting (update_waiting[ch])
    );
  end

  // Interface control fields.
  assign format_select              = dcrb_format_t'(iface_r[`DCRB_FMT_LSB +: 2]);
  assign frame_clock_polarity_phase = iface_r[`DCRB_LRP_BIT];
  assign frame_clock_invert         = frame_inv_r;
  assign dsp_late_phase             = dsp_late_r;
  assign bit_clock_polarity         = iface_r[`DCRB_BCP_BIT];
  assign input_word_length          = dcrb_word_len_t'(iface_r[`DCRB_IWL_LSB +: 2]);
  assign word_bits                  = bits_r;
  assign config_conflict            = conflict_r;
  assign phase_invert               = iface_r[`DCRB_REV_LSB +: 3];

  // Extended control fields.
  assign split_rate_enable  = ext_r[`DCRB_SPLIT_BIT];
  // The four rear channels run at half the front rate while split rate is on.
  assign rear_half_rate     = ext_r[`DCRB_SPLIT_BIT];
  assign zero_cross_disable = ext_r[`DCRB_ZCD_BIT];

  // Levels.
  assign master_level        = master_r;
  assign left_pair1_level    = applied[0];
  assign right_pair1_level   = applied[1];
  assign left_pair2_level    = applied[2];
  assign right_pair2_level   = applied[3];
  assign left_pair1_pending  = pending[0];
  assign right_pair1_pending = pending[1];
  assign left_pair2_pending  = pending[2];
  assign right_pair2_pending = pending[3];
  assign update_strobe       = strobe_r;
endmodule : dcrb_top

// ### dcrb_props.sv
// Concurrent checks on the outputs of the converter control bank, bound into dcrb_top.
// Assumes one clock, core_clk, and a synchronous active-low reset_n.
`timescale 1ns/1ps
module dcrb_props #(
  parameter int LEVEL_W  = 8,
  parameter int CHANNELS = 4
)
(
  input wire logic                core_clk,
  input wire logic                reset_n,
  input wire logic [CHANNELS-1:0] midrail_cross,
  input dcrb_pkg::dcrb_format_t   format_select,
  input wire logic                frame_clock_polarity_phase,
  input wire logic                frame_clock_invert,
  input wire logic                dsp_late_phase,
  input dcrb_pkg::dcrb_word_len_t input_word_length,
  input wire logic [5:0]          word_bits,
  input wire logic                config_conflict,
  input wire logic                split_rate_enable,
  input wire logic                rear_half_rate,
  input wire logic                zero_cross_disable,
  input wire logic [LEVEL_W-1:0]  master_level,
  input wire logic [LEVEL_W-1:0]  left_pair1_level,
  input wire logic [LEVEL_W-1:0]  right_pair2_level,
  input wire logic [LEVEL_W-1:0]  left_pair1_pending,
  input wire logic [LEVEL_W-1:0]  right_pair2_pending,
  input wire logic [CHANNELS-1:0] update_waiting,
  input wire logic                update_strobe
);
  import dcrb_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  dsp_phase_a: assert property (
    dsp_late_phase == (frame_clock_polarity_phase && format_select == DCRB_FMT_DSP))
    else $error("dsp phase flag wrong");
  frame_invert_a: assert property (
    frame_clock_invert == (frame_clock_polarity_phase && format_select != DCRB_FMT_DSP))
    else $error("frame clock invert flag wrong");
  word_bits_a: assert property (
    word_bits == (input_word_length == DCRB_WL_32 ? 6'h20 : 6'h10 + {2'h0, input_word_length, 2'h0}))
    else $error("decoded word length wrong");
  conflict_flag_a: assert property (
    config_conflict == (input_word_length == DCRB_WL_32 && format_select == DCRB_FMT_RIGHT_JUST))
    else $error("conflict flag wrong");
  rear_rate_a: assert property (
    rear_half_rate == split_rate_enable)
    else $error("rear rate flag wrong");
  strobe_pulse_a: assert property (
    update_strobe |=> !update_strobe)
    else $error("update strobe longer than one cycle");
  apply_cause_a: assert property (
    $changed(left_pair1_level) |-> update_strobe || $past(midrail_cross[0]))
    else $error("applied level changed without commit or crossing");
  commit_copy_a: assert property (
    update_strobe && zero_cross_disable |=> {left_pair1_level, right_pair2_level} ==
    $past({left_pair1_pending, right_pair2_pending}))
    else $error("commit did not apply latches");
  wait_hold_a: assert property (
    update_waiting[0] && !midrail_cross[0] && !zero_cross_disable |=> update_waiting[0])
    else $error("waiting cleared without crossing");
  cross_clear_a: assert property (
    update_waiting[0] && midrail_cross[0] && !update_strobe |=> !update_waiting[0])
    else $error("crossing did not clear waiting");
  bypass_nowait_a: assert property (
    update_strobe && zero_cross_disable |=> !(|update_waiting))
    else $error("waiting set with gating off");
  master_copy_a: assert property (
    $changed(master_level) |-> left_pair1_pending == master_level && right_pair2_pending == master_level)
    else $error("master value not copied to latches");
endmodule : dcrb_props

bind dcrb_top dcrb_props #(.LEVEL_W(LEVEL_W), .CHANNELS(CHANNELS)) i_props
(
  .core_clk, .reset_n, .midrail_cross, .format_select, .frame_clock_polarity_phase, .frame_clock_invert,
  .dsp_late_phase, .input_word_length, .word_bits, .config_conflict, .split_rate_enable, .rear_half_rate,
  .zero_cross_disable, .master_level, .left_pair1_level, .right_pair2_level, .left_pair1_pending,
  .right_pair2_pending, .update_waiting, .update_strobe
);

// ### dcrb_host_model.sv
// Host controller model that writes words over the three-wire control port.
// Assumes core_clk paces it; every pin level is held for at least four core_clk cycles.
`timescale 1ns/1ps
module dcrb_host_model
(
  input  wire logic core_clk,
  output logic      ctl_latch_pin,
  output logic      ctl_clock_pin,
  output logic      ctl_data_pin
);
  initial
  begin
    ctl_latch_pin = 1'b0;
    ctl_clock_pin = 1'b0;
    ctl_data_pin  = 1'b0;
  end
  task automatic hold();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : hold
  task automatic send(input logic [6:0] addr, input logic [8:0] data);
    logic [15:0] word;
    word = {addr, data};
    for (int i = 15; i >= 0; i--)
    begin
      ctl_data_pin = word[i];
      hold();
      ctl_clock_pin = 1'b1;
      hold();
      ctl_clock_pin = 1'b0;
      hold();
    end
    // The data line no longer carries a valid bit, so it shows the opposite level.
    ctl_data_pin  = ~ctl_data_pin;
    ctl_latch_pin = 1'b1;
    hold();
    ctl_latch_pin = 1'b0;
    hold();
  endtask : send
endmodule : dcrb_host_model

// ### tb.sv
// Self-checking bench for the converter control bank.
// Assumes the host model drives the control pins and the bench pulses the midrail crossings.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb;
  import dcrb_pkg::*;
  logic                   core_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [3:0]             midrail_cross = 4'h0;
  wire                    ctl_latch_pin, ctl_clock_pin, ctl_data_pin;
  dcrb_format_t           format_select;
  dcrb_word_len_t         input_word_length;
  logic                   frame_clock_polarity_phase, bit_clock_polarity, split_rate_enable, zero_cross_disable;
  logic [2:0]             phase_invert;
  logic [5:0]             word_bits;
  logic [3:0]             update_waiting;
  logic [7:0]             master_level, left_pair1_level, right_pair1_level, left_pair2_level, right_pair2_level;
  logic [7:0]             left_pair1_pending, right_pair1_pending, left_pair2_pending, right_pair2_pending;
  int                     fail_count = 0;
  int                     n_compared = 0;
  wire [8:0]              iface = {phase_invert, input_word_length, bit_clock_polarity, frame_clock_polarity_phase,
                                   format_select};
  wire [1:0]              ext = {zero_cross_disable, split_rate_enable};
  wire [31:0]             levels = {left_pair1_level, right_pair1_level, left_pair2_level, right_pair2_level};
  wire [31:0]             pendings = {left_pair1_pending, right_pair1_pending, left_pair2_pending, right_pair2_pending};
  // Each row: address, data written, expected interface settings, expected extended settings.
  logic [26:0]            rows [10] = '{
    {7'h03, 9'h001, 9'h001, 2'h0},
    {7'h03, 9'h016, 9'h016, 2'h0},
    {7'h03, 9'h0ab, 9'h0ab, 2'h0},
    {7'h03, 9'h1f7, 9'h1f7, 2'h0},
    {7'h03, 9'h030, 9'h030, 2'h0},
    {7'h03, 9'h048, 9'h048, 2'h0},
    {7'h0a, 9'h1ff, 9'h048, 2'h0},
    {7'h09, 9'h001, 9'h048, 2'h1},
    {7'h09, 9'h1fe, 9'h048, 2'h2},
    {7'h02, 9'h0ff, 9'h048, 2'h2}};

  always #4 core_clk = ~core_clk;

  dcrb_host_model i_host (.core_clk, .ctl_latch_pin, .ctl_clock_pin, .ctl_data_pin);

  dcrb_top i_dut (.core_clk, .reset_n, .ctl_latch_pin, .ctl_clock_pin, .ctl_data_pin, .midrail_cross,
    .format_select, .frame_clock_polarity_phase, .frame_clock_invert(), .dsp_late_phase(), .bit_clock_polarity,
    .input_word_length, .word_bits, .config_conflict(), .phase_invert, .split_rate_enable, .rear_half_rate(),
    .zero_cross_disable, .master_level, .left_pair1_level, .right_pair1_level, .left_pair2_level,
    .right_pair2_level, .left_pair1_pending, .right_pair1_pending, .left_pair2_pending, .right_pair2_pending,
    .update_waiting, .update_strobe());

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    i_host.send(a, d);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : wr

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      wr(rows[i][26:20], rows[i][19:11]);
      `CHK("iface", rows[i][10:2], iface)
      `CHK("ext", rows[i][1:0], ext)
    end
    wr(7'h04, 9'h010);
    wr(7'h05, 9'h011);
    `CHK("latched", {32'h10110000, 32'hffffffff}, {pendings[31:16], 16'h0000, levels})
    wr(7'h07, 9'h120);
    `CHK("applied", 32'h1011ff20, levels)
    wr(7'h06, 9'h030);
    `CHK("l2 pair", 16'hff30, {left_pair2_level, left_pair2_pending})
    wr(7'h08, 9'h040);
    `CHK("master latch", 64'h404040401011ff20, {pendings, levels})
    wr(7'h08, 9'h155);
    `CHK("master apply", 40'h5555555555, {master_level, levels})
    wr(7'h09, 9'h000);
    wr(7'h04, 9'h170);
    `CHK("gated", {8'h55, 1'b1}, {left_pair1_level, update_waiting[0]})
    midrail_cross = 4'h1;
    @(posedge core_clk);
    #1 midrail_cross = 4'h0;
    @(posedge core_clk);
    #1;
    `CHK("crossed", {8'h70, 1'b0}, {left_pair1_level, update_waiting[0]})
    reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    `CHK("reset regs", 11'h000, {iface, ext})
    `CHK("reset levels", 40'hffffffffff, {master_level, levels})
    `CHK("reset latches", 32'hffffffff, pendings)
    `CHK("reset misc", {6'h10, 4'h0}, {word_bits, update_waiting})
    print_verdict();
  end
endmodule : tb
